// [ddr_port_steering_arbiter.sv]
// core port steering and ddr arbitration with ecc and registers
//
// Behaviour
// - Core ddr traffic uses the dedicated port when bit 31 is set.
// - The steering bit resets to zero, so core traffic starts on the bus.
// - The flash alias bit resets to one: flash at 0x0 and 0x5000_0000.
// - Steered core accesses below 1 Gbyte take the dedicated port.
// - Quota bits 7:4 cap bus side transfers per tenure, zero means 16.
// - Quota bits 3:0 cap core port transfers per tenure, zero means 16.
// - The quota register does not reset to the equal bandwidth value.
// - Ecc corrects single-bit and flags double-bit read errors.
// - Ecc errors raise an interrupt so software can handle and scrub.
// - The uncorrectable error drives its own interrupt line.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
module ddr_port_steering_arbiter
  import ddr_arb_pkg::*;
(
  input  wire logic                  clk_i,          // 20 MHz clock
  input  wire logic                  rst_b_i,        // async reset, low
  input  wire logic                  ce_i,           // clock enable
  // register port
  input  wire logic [REG_ADDR_W-1:0] reg_addr_i,     // byte address
  input  wire logic [DATA_W-1:0]     reg_wdata_i,    // write data
  input  wire logic                  reg_wr_i,       // write strobe
  input  wire logic                  reg_rd_i,       // read strobe
  output logic      [DATA_W-1:0]     reg_rdata_o,    // read data
  // core requester
  input  wire logic                  core_req_i,     // core request
  input  wire logic                  core_we_i,      // core write
  input  wire logic [31:0]           core_addr_i,    // core address
  input  wire logic [DATA_W-1:0]     core_wdata_i,   // core write data
  output logic                       core_ack_o,     // core done pulse
  output logic      [DATA_W-1:0]     core_rdata_o,   // core read data
  output logic                       core_dedicated_o, // last via port
  // north/south ahb requester
  input  wire logic                  ahb_req_i,      // bus request
  input  wire logic                  ahb_we_i,       // bus write
  input  wire logic [31:0]           ahb_addr_i,     // bus address
  input  wire logic [DATA_W-1:0]     ahb_wdata_i,    // bus write data
  output logic                       ahb_ack_o,      // bus done pulse
  output logic      [DATA_W-1:0]     ahb_rdata_o,    // bus read data
  // memory controller
  output logic                       mc_req_o,       // mc request
  output logic                       mc_we_o,        // mc write
  output logic      [31:0]           mc_addr_o,      // mc address
  output logic      [DATA_W-1:0]     mc_wdata_o,     // mc write data
  output logic      [CHECK_W-1:0]    mc_wcheck_o,    // mc write check
  input  wire logic                  mc_ack_i,       // mc done
  input  wire logic [DATA_W-1:0]     mc_rdata_i,     // mc read data
  input  wire logic [CHECK_W-1:0]    mc_rcheck_i,    // mc read check
  // configuration and interrupts
  output logic                       port_steering_enable_o, // steer
  output logic                       boot_flash_alias_o,     // alias
  output logic                       irq_o,          // ecc interrupt
  output logic                       multibit_irq_o  // double error
);

  arb_if arb ();
  ecc_if ecc ();

  tenure_arbiter u_arb
  (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .ce_i    (ce_i),
    .arb     (arb)
  );

  secded_codec u_ecc
  (
    .ecc (ecc)
  );

  mc_state_t          state_reg;
  logic [31:0]        exp_cfg0_reg;
  logic [31:0]        exp_cfg1_reg;
  logic [7:0]         quota_reg;
  logic [IRQ_W-1:0]   irq_status_reg;
  logic [IRQ_W-1:0]   irq_mask_reg;
  logic               ecc_enable_reg;
  logic               cur_bus_reg;
  logic               cur_ext_reg;
  logic               cur_we_reg;
  logic [IRQ_W-1:0]   irq_event;
  logic               steer_en;
  logic               core_direct;
  logic               core_on_bus;
  logic               ext_pick;
  logic               wr_hit;
  logic               rd_hit;
  logic [DATA_W-1:0]  rd_value;
  logic [DATA_W-1:0]  read_word;
  logic               mc_done;

  assign steer_en = exp_cfg1_reg[BIT_PORT_STEERING_EN];
  assign port_steering_enable_o = exp_cfg1_reg[BIT_PORT_STEERING_EN];
  assign boot_flash_alias_o     = exp_cfg0_reg[BIT_BOOT_FLASH_ALIAS];

  // core traffic split between dedicated port and bus side
  always_comb
  begin
    core_direct = core_req_i && steer_en
                  && (core_addr_i < LOW_WINDOW_LIMIT);
    core_on_bus = core_req_i && !core_direct;
    ext_pick    = ahb_req_i;
  end

  always_comb
  begin
    arb.req_core   = core_direct;
    arb.req_bus    = ahb_req_i || core_on_bus;
    arb.quota_core = quota_count(
      quota_reg[QUOTA_CORE_LSB +: QUOTA_FIELD_W]);
    arb.quota_bus  = quota_count(
      quota_reg[QUOTA_BUS_LSB +: QUOTA_FIELD_W]);
    arb.start      = (state_reg == ST_IDLE)
                     && (arb.req_core || arb.req_bus);
  end

  assign mc_done = (state_reg == ST_ISSUE) && mc_ack_i;

  // ecc codec hookup
  always_comb
  begin
    ecc.wdata  = (arb.sel_bus && ext_pick) ? ahb_wdata_i : core_wdata_i;
    ecc.rdata  = mc_rdata_i;
    ecc.rcheck = mc_rcheck_i;
    read_word  = ecc_enable_reg ? ecc.fixed : mc_rdata_i;
    irq_event  = '0;
    if (mc_done && !cur_we_reg && ecc_enable_reg)
    begin
      irq_event[BIT_IRQ_SINGLE] = ecc.single_err;
      irq_event[BIT_IRQ_DOUBLE] = ecc.double_err;
    end
  end

  // transaction sequencer
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg   <= ST_IDLE;
      mc_req_o    <= 1'b0;
      mc_we_o     <= 1'b0;
      mc_addr_o   <= '0;
      mc_wdata_o  <= '0;
      mc_wcheck_o <= '0;
      cur_bus_reg <= 1'b0;
      cur_ext_reg <= 1'b0;
      cur_we_reg  <= 1'b0;
    end
    else if (ce_i)
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (arb.start)
          begin
            cur_bus_reg <= arb.sel_bus;
            cur_ext_reg <= arb.sel_bus && ext_pick;
            mc_req_o    <= 1'b1;
            mc_wdata_o  <= ecc.wdata;
            mc_wcheck_o <= ecc.wcheck;
            if (arb.sel_bus && ext_pick)
            begin
              mc_we_o    <= ahb_we_i;
              mc_addr_o  <= ahb_addr_i;
              cur_we_reg <= ahb_we_i;
            end
            else
            begin
              mc_we_o    <= core_we_i;
              mc_addr_o  <= core_addr_i;
              cur_we_reg <= core_we_i;
            end
            state_reg <= ST_ISSUE;
          end
        end
        ST_ISSUE:
        begin
          if (mc_ack_i)
          begin
            mc_req_o  <= 1'b0;
            state_reg <= ST_RESP;
          end
        end
        ST_RESP:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // answers to the requesters
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      core_ack_o       <= 1'b0;
      ahb_ack_o        <= 1'b0;
      core_rdata_o     <= '0;
      ahb_rdata_o      <= '0;
      core_dedicated_o <= 1'b0;
    end
    else if (ce_i)
    begin
      core_ack_o <= mc_done && !cur_ext_reg;
      ahb_ack_o  <= mc_done && cur_ext_reg;
      if (mc_done && !cur_ext_reg)
      begin
        core_dedicated_o <= !cur_bus_reg;
        if (!cur_we_reg)
          core_rdata_o <= read_word;
      end
      if (mc_done && cur_ext_reg && !cur_we_reg)
        ahb_rdata_o <= read_word;
    end
  end

  assign wr_hit = ce_i && reg_wr_i;
  assign rd_hit = ce_i && reg_rd_i;

  // configuration registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      exp_cfg0_reg   <= RST_EXP_CONFIG_ZERO;
      exp_cfg1_reg   <= RST_EXP_CONFIG_ONE;
      quota_reg      <= RST_PORT_QUOTA;
      irq_mask_reg   <= RST_IRQ_MASK;
      ecc_enable_reg <= RST_ECC_ENABLE;
    end
    else if (wr_hit)
    begin
      unique case (reg_addr_i)
        OFS_EXP_CONFIG_ZERO: exp_cfg0_reg <= reg_wdata_i;
        OFS_EXP_CONFIG_ONE:  exp_cfg1_reg <= reg_wdata_i;
        OFS_PORT_QUOTA:      quota_reg <= reg_wdata_i[7:0];
        OFS_IRQ_MASK:        irq_mask_reg <= reg_wdata_i[IRQ_W-1:0];
        OFS_ECC_CONTROL:     ecc_enable_reg <= reg_wdata_i[BIT_ECC_ENABLE];
        default:             ;
      endcase
    end
  end

  // sticky ecc status, read clears, new event wins
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      irq_status_reg <= '0;
    else if (ce_i)
    begin
      if (rd_hit && (reg_addr_i == OFS_IRQ_STATUS))
        irq_status_reg <= irq_event;
      else
        irq_status_reg <= irq_status_reg | irq_event;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_o          <= 1'b0;
      multibit_irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_o <= |(irq_status_reg & irq_mask_reg);
      multibit_irq_o <= irq_status_reg[BIT_IRQ_DOUBLE]
                        & irq_mask_reg[BIT_IRQ_DOUBLE];
    end
  end

  // read mux
  always_comb
  begin
    rd_value = '0;
    unique case (reg_addr_i)
      OFS_EXP_CONFIG_ZERO: rd_value = exp_cfg0_reg;
      OFS_EXP_CONFIG_ONE:  rd_value = exp_cfg1_reg;
      OFS_PORT_QUOTA:      rd_value[7:0] = quota_reg;
      OFS_IRQ_STATUS:      rd_value[IRQ_W-1:0] = irq_status_reg;
      OFS_IRQ_MASK:        rd_value[IRQ_W-1:0] = irq_mask_reg;
      OFS_ECC_CONTROL:     rd_value[BIT_ECC_ENABLE] = ecc_enable_reg;
      OFS_ARB_STATUS:      rd_value[15:0] = {5'h00, state_reg,
                                             2'h0, arb.owner_bus,
                                             arb.tenure_cnt};
      default:             rd_value = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      reg_rdata_o <= '0;
    else if (ce_i)
      reg_rdata_o <= rd_hit ? rd_value : '0;
  end

endmodule // ddr_port_steering_arbiter

// [ddr_arb_pkg.sv]
// constants, types and helpers shared by the ddr port steering arbiter
package ddr_arb_pkg;

  localparam int unsigned REG_ADDR_W = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned CHECK_W    = 7;
  localparam int unsigned QCNT_W     = 5;

  // register byte offsets
  localparam logic [7:0] OFS_EXP_CONFIG_ZERO = 8'h00;
  localparam logic [7:0] OFS_EXP_CONFIG_ONE  = 8'h04;
  localparam logic [7:0] OFS_PORT_QUOTA      = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS      = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK        = 8'h10;
  localparam logic [7:0] OFS_ECC_CONTROL     = 8'h14;
  localparam logic [7:0] OFS_ARB_STATUS      = 8'h18;

  // field positions
  localparam int unsigned BIT_BOOT_FLASH_ALIAS  = 0;
  localparam int unsigned BIT_PORT_STEERING_EN  = 31;
  localparam int unsigned QUOTA_BUS_LSB         = 4;
  localparam int unsigned QUOTA_CORE_LSB        = 0;
  localparam int unsigned QUOTA_FIELD_W         = 4;
  localparam int unsigned BIT_ECC_ENABLE        = 0;
  localparam int unsigned BIT_IRQ_SINGLE        = 0;
  localparam int unsigned BIT_IRQ_DOUBLE        = 1;
  localparam int unsigned IRQ_W                 = 2;

  // reset values
  localparam logic [31:0] RST_EXP_CONFIG_ZERO = 32'h0000_0001;
  localparam logic [31:0] RST_EXP_CONFIG_ONE  = 32'h0000_0000;
  localparam logic [7:0]  RST_PORT_QUOTA      = 8'h01;
  localparam logic [1:0]  RST_IRQ_MASK        = 2'h0;
  localparam logic        RST_ECC_ENABLE      = 1'b0;

  // core accesses below this address are ddr accesses
  localparam logic [31:0] LOW_WINDOW_LIMIT = 32'h4000_0000;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_ISSUE = 3'b010,
    ST_RESP  = 3'b100
  } mc_state_t;

  // quota field to transaction count, zero meaning sixteen
  function automatic logic [QCNT_W-1:0] quota_count
  (
    input logic [QUOTA_FIELD_W-1:0] field
  );
    quota_count = (field == 4'h0) ? 5'h10 : {1'b0, field};
  endfunction

endpackage

// [ddr_arb_if.sv]
// carriers between the top and its arbiter and ecc helpers
`timescale 1ns/1ns
interface arb_if;
  import ddr_arb_pkg::*;
  logic              req_core;
  logic              req_bus;
  logic              start;
  logic [QCNT_W-1:0] quota_core;
  logic [QCNT_W-1:0] quota_bus;
  logic              sel_bus;
  logic              owner_bus;
  logic [QCNT_W-1:0] tenure_cnt;
  modport arbiter (input req_core, req_bus, start, quota_core, quota_bus,
                   output sel_bus, owner_bus, tenure_cnt);
  modport user    (output req_core, req_bus, start, quota_core, quota_bus,
                   input sel_bus, owner_bus, tenure_cnt);
endinterface

interface ecc_if;
  import ddr_arb_pkg::*;
  logic [DATA_W-1:0]  wdata;
  logic [CHECK_W-1:0] wcheck;
  logic [DATA_W-1:0]  rdata;
  logic [CHECK_W-1:0] rcheck;
  logic [DATA_W-1:0]  fixed;
  logic               single_err;
  logic               double_err;
  modport codec (input wdata, rdata, rcheck,
                 output wcheck, fixed, single_err, double_err);
  modport user  (output wdata, rdata, rcheck,
                 input wcheck, fixed, single_err, double_err);
endinterface

// [tenure_arbiter.sv]
// two-port ddr tenure arbiter with per-port transaction quotas
`timescale 1ns/1ns
module tenure_arbiter
  import ddr_arb_pkg::*;
(
  input  wire logic clk_i,   // system clock
  input  wire logic rst_b_i, // async reset, active low
  input  wire logic ce_i,    // clock enable
  arb_if.arbiter    arb      // request and tenure state
);

  logic              own_req;
  logic              other_req;
  logic [QCNT_W-1:0] own_quota;

  always_comb
  begin
    own_req   = arb.owner_bus ? arb.req_bus : arb.req_core;
    other_req = arb.owner_bus ? arb.req_core : arb.req_bus;
    own_quota = arb.owner_bus ? arb.quota_bus : arb.quota_core;
    // stay while quota lasts, else hand over to a waiting port
    if (own_req && (arb.tenure_cnt < own_quota))
      arb.sel_bus = arb.owner_bus;
    else if (other_req)
      arb.sel_bus = ~arb.owner_bus;
    else
      arb.sel_bus = arb.owner_bus;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      arb.owner_bus  <= 1'b0;
      arb.tenure_cnt <= '0;
    end
    else if (ce_i && arb.start)
    begin
      if (arb.sel_bus != arb.owner_bus)
      begin
        arb.owner_bus  <= arb.sel_bus;
        arb.tenure_cnt <= 5'h01;
      end
      else if (arb.tenure_cnt >= own_quota)
        arb.tenure_cnt <= 5'h01; // fresh tenure, same port
      else
        arb.tenure_cnt <= arb.tenure_cnt + 5'h01;
    end
  end

endmodule // tenure_arbiter

// [secded_codec.sv]
// single-error-correct double-error-detect codec for 32-bit words
`timescale 1ns/1ns
module secded_codec
  import ddr_arb_pkg::*;
(
  ecc_if.codec ecc // write encode and read decode
);

  // hamming positions 1..38, checks at powers of two
  function automatic logic [38:1] spread(input logic [DATA_W-1:0] d);
    int unsigned k;
    spread = '0;
    k = 0;
    for (int p = 1; p <= 38; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        spread[p] = d[k];
        k++;
      end
    end
  endfunction

  function automatic logic [5:0] syndrome(input logic [38:1] c);
    syndrome = '0;
    for (int p = 1; p <= 38; p++)
      if (c[p])
        syndrome = syndrome ^ p[5:0];
  endfunction

  function automatic logic [DATA_W-1:0] gather(input logic [38:1] c);
    int unsigned k;
    gather = '0;
    k = 0;
    for (int p = 1; p <= 38; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        gather[k] = c[p];
        k++;
      end
    end
  endfunction

  logic [38:1] wcode;
  logic [38:1] rcode;
  logic [5:0]  wsyn;
  logic [5:0]  rsyn;
  logic        rpar_bad;

  always_comb
  begin
    wcode = spread(ecc.wdata);
    wsyn  = syndrome(wcode);
    ecc.wcheck = {^{wcode, wsyn}, wsyn};
    rcode = spread(ecc.rdata);
    for (int i = 0; i < 6; i++)
      rcode[1 << i] = ecc.rcheck[i];
    rsyn     = syndrome(rcode);
    rpar_bad = ^{rcode, ecc.rcheck[6]};
    // odd parity error: one flipped bit, repaired in place
    if (rpar_bad && (rsyn != 6'h00) && (rsyn <= 6'd38))
      rcode[rsyn] = ~rcode[rsyn];
    ecc.fixed      = gather(rcode);
    ecc.single_err = rpar_bad;
    ecc.double_err = !rpar_bad && (rsyn != 6'h00);
  end

endmodule // secded_codec

// [ddr_arb_assertions.sv]
// port assertions for the ddr port steering arbiter
`timescale 1ns/1ns
module ddr_arb_assertions
  import ddr_arb_pkg::*;
(
  input wire logic              clk_i,           // clock
  input wire logic              rst_b_i,         // reset
  input wire logic              ce_i,            // enable
  input wire logic [7:0]        reg_addr_i,      // addr
  input wire logic [DATA_W-1:0] reg_wdata_i,     // wdata
  input wire logic              reg_wr_i,        // write
  input wire logic              reg_rd_i,        // read
  input wire logic [DATA_W-1:0] reg_rdata_o,     // rdata
  input wire logic [31:0]       core_addr_i,     // core addr
  input wire logic              core_ack_o,      // core ack
  input wire logic              core_dedicated_o, // route
  input wire logic              ahb_ack_o,       // bus ack
  input wire logic              mc_req_o,        // mc req
  input wire logic              mc_we_o,         // mc we
  input wire logic [31:0]       mc_addr_o,       // mc addr
  input wire logic [DATA_W-1:0] mc_wdata_o,      // mc data
  input wire logic              mc_ack_i,        // mc ack
  input wire logic              port_steering_enable_o, // steer
  input wire logic              irq_o,           // irq
  input wire logic              multibit_irq_o   // double irq
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_RD_IDLE: assert property ($past(ce_i) && !$past(reg_rd_i)
    |-> reg_rdata_o == '0) else $error("read data outside slot");
  AST_RD_UNMAPPED: assert property (reg_rd_i && ce_i && reg_addr_i == 8'h1c
    |=> reg_rdata_o == '0) else $error("unmapped read not zero");
  AST_STEER_WR: assert property (reg_wr_i && ce_i &&
    reg_addr_i == OFS_EXP_CONFIG_ONE |=> port_steering_enable_o ==
    $past(reg_wdata_i[31])) else $error("steering bit not written");
  AST_ROUTE: assert property (core_ack_o |-> core_dedicated_o ==
    (port_steering_enable_o && core_addr_i < 32'h4000_0000))
    else $error("core transfer on wrong port");
  AST_ACK_CAUSE: assert property (core_ack_o || ahb_ack_o
    |-> $past(mc_ack_i) && !(core_ack_o && ahb_ack_o))
    else $error("ack without controller done");
  AST_ACK_PULSE: assert property (core_ack_o || ahb_ack_o
    |=> !core_ack_o && !ahb_ack_o) else $error("ack longer than a cycle");
  AST_MC_HOLD: assert property (mc_req_o && !mc_ack_i |=> mc_req_o &&
    $stable(mc_addr_o) && $stable(mc_wdata_o) && $stable(mc_we_o))
    else $error("controller request changed while waiting");
  AST_MC_DROP: assert property (mc_req_o && mc_ack_i && ce_i
    |=> !mc_req_o) else $error("controller request held after done");
  AST_MULTI_IRQ: assert property (multibit_irq_o |-> irq_o)
    else $error("double error line without interrupt");

  COV_DOUBLE: cover property (multibit_irq_o);
  COV_DEDICATED: cover property (core_ack_o && core_dedicated_o);
  COV_BUS: cover property (ahb_ack_o);
endmodule // ddr_arb_assertions

bind ddr_port_steering_arbiter ddr_arb_assertions chk (.*);

// [mc_model.sv]
// memory controller model with ack delay and read bit flips
`timescale 1ns/1ns
module mc_model
  import ddr_arb_pkg::*;
(
  input  wire logic               clk_i,    // clock
  input  wire logic               rst_b_i,  // reset, low
  input  wire logic               req_i,    // request
  input  wire logic               we_i,     // write
  input  wire logic [31:0]        addr_i,   // address
  input  wire logic [DATA_W-1:0]  wdata_i,  // write data
  input  wire logic [CHECK_W-1:0] wcheck_i, // write check
  input  wire logic [3:0]         delay_i,  // ack delay
  input  wire logic [DATA_W-1:0]  flip_i,   // read flips
  output logic                    ack_o,    // done pulse
  output logic      [DATA_W-1:0]  rdata_o,  // read data
  output logic      [CHECK_W-1:0] rcheck_o  // read check
);
  logic [DATA_W-1:0]  mem [16];
  logic [CHECK_W-1:0] chk [16];
  logic [3:0]         wait_reg;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ack_o    <= 1'b0;
      wait_reg <= 4'h0;
      rdata_o  <= '0;
      rcheck_o <= '0;
    end
    else
    begin
      ack_o    <= 1'b0;
      // outside the answer the lines keep moving
      rdata_o  <= ~rdata_o;
      rcheck_o <= ~rcheck_o;
      if (req_i && !ack_o)
      begin
        wait_reg <= wait_reg + 4'h1;
        if (wait_reg >= delay_i)
        begin
          ack_o    <= 1'b1;
          wait_reg <= 4'h0;
          if (we_i)
          begin
            mem[addr_i[5:2]] <= wdata_i;
            chk[addr_i[5:2]] <= wcheck_i;
          end
          rdata_o  <= mem[addr_i[5:2]] ^ flip_i;
          rcheck_o <= chk[addr_i[5:2]];
        end
      end
    end
  end
endmodule // mc_model

// [testbench.sv]
// self-checking bench for the ddr port steering arbiter
`timescale 1ns/1ns
module testbench;
  import ddr_arb_pkg::*;
  localparam logic [31:0] RST_TAB [8] = '{32'h1, 32'h0, 32'h1, 32'h0,
                                          32'h0, 32'h0, 32'h100, 32'h0};
  localparam logic [7:0]  QTAB [4] = '{8'h11, 8'h32, 8'h01, 8'h10};
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, core_addr_i, core_wdata_i;
  logic [31:0] core_rdata_o, ahb_addr_i, ahb_wdata_i, ahb_rdata_o;
  logic [31:0] mc_addr_o, mc_wdata_o, mc_rdata_i, flip, seed, rv, rv2, a;
  logic [6:0]  mc_wcheck_o, mc_rcheck_i;
  logic [3:0]  dly;
  logic        clk_i, rst_b_i, ce_i, reg_wr_i, reg_rd_i, core_req_i, s;
  logic        core_we_i, core_ack_o, core_dedicated_o, ahb_req_i;
  logic        ahb_we_i, ahb_ack_o, mc_req_o, mc_we_o, mc_ack_i;
  logic        port_steering_enable_o, boot_flash_alias_o, irq_o;
  logic        multibit_irq_o, last, log_en;
  int          err_count, checked, cycles, run, maxc, maxb;

  ddr_port_steering_arbiter DUT (.*);
  mc_model mc (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(mc_req_o),
    .we_i(mc_we_o), .addr_i(mc_addr_o), .wdata_i(mc_wdata_o),
    .wcheck_i(mc_wcheck_o), .delay_i(dly), .flip_i(flip),
    .ack_o(mc_ack_i), .rdata_o(mc_rdata_i), .rcheck_o(mc_rcheck_i));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int q_exp(input logic [3:0] f);
    q_exp = (f == 4'h0) ? 16 : int'(f);
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h", $time, m, got);
    end
  endtask
  task automatic chk_bit(input logic got, exp, input string m);
    chk_word({31'h0, got}, {31'h0, exp}, m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= ad;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= ad;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // one transfer from core (c=1) or bus side (c=0), waits for its ack
  task automatic xfer(input logic c, w, input logic [31:0] ad, d,
                      output logic [31:0] q);
    int n;
    @(posedge clk_i);
    if (c)
    begin
      core_req_i   <= 1'b1;
      core_we_i    <= w;
      core_addr_i  <= ad;
      core_wdata_i <= d;
    end
    else
    begin
      ahb_req_i   <= 1'b1;
      ahb_we_i    <= w;
      ahb_addr_i  <= ad;
      ahb_wdata_i <= d;
    end
    n = 0;
    do
    begin
      tick(1);
      n++;
    end
    while ((c ? core_ack_o : ahb_ack_o) !== 1'b1 && n < 100);
    q = c ? core_rdata_o : ahb_rdata_o;
    chk_bit(n < 100, 1'b1, "ack wait");
    @(posedge clk_i);
    if (c)
      core_req_i <= 1'b0;
    else
      ahb_req_i <= 1'b0;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      results();
    end
  end
  // length of same-port runs of acks while both ports request
  always @(posedge clk_i)
    if (log_en && (core_ack_o === 1'b1 || ahb_ack_o === 1'b1))
    begin
      run = (ahb_ack_o === last) ? run + 1 : 1;
      last = ahb_ack_o;
      if (last)
        maxb = (run > maxb) ? run : maxb;
      else
        maxc = (run > maxc) ? run : maxc;
    end

  initial
  begin
    {reg_wr_i, reg_rd_i, core_req_i, core_we_i, ahb_req_i} = '0;
    {ahb_we_i, last, log_en, s} = '0;
    {reg_addr_i, reg_wdata_i, core_addr_i, core_wdata_i} = '0;
    {ahb_addr_i, ahb_wdata_i, flip, dly} = '0;
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    seed = 32'd76039;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    tick(1);
    chk_bit(port_steering_enable_o, 1'b0, "steer at reset");
    chk_bit(boot_flash_alias_o, 1'b1, "alias at reset");
    for (int i = 0; i < 8; i++)
    begin
      rd(8'(i * 4), rv);
      chk_word(rv, RST_TAB[i], "reset value");
    end
    wr(OFS_ARB_STATUS, '1);
    wr(8'h1c, '1);
    wr(OFS_EXP_CONFIG_ONE, 32'h8000_0000);
    rd(OFS_ARB_STATUS, rv);
    chk_word(rv, 32'h100, "read only status");
    rd(8'h1c, rv);
    chk_word(rv, 32'h0, "unmapped");
    rd(OFS_EXP_CONFIG_ONE, rv);
    chk_word(rv, 32'h8000_0000, "steer readback");
    chk_bit(port_steering_enable_o, 1'b1, "steer out");
    @(posedge clk_i) ce_i <= 1'b0;
    wr(OFS_EXP_CONFIG_ONE, 32'h0);
    ce_i <= 1'b1;
    chk_bit(port_steering_enable_o, 1'b1, "frozen");
    $display("test registers done");
    wr(OFS_PORT_QUOTA, 32'h11);
    wr(OFS_ECC_CONTROL, 32'h1);
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      a = {seed[31:30], 24'h0, seed[5:2], 2'b00};
      a = (i == 0) ? 32'h3fff_fffc : (i == 1) ? 32'h4000_0000 : a;
      s = seed[7] | (i < 2);
      dly = seed[11:8] & 4'h7;
      wr(OFS_EXP_CONFIG_ONE, {s, 31'h0});
      seed = lfsr(seed);
      xfer(1'b1, 1'b1, a, seed, rv);
      chk_bit(core_dedicated_o, s && a < 32'h4000_0000,
              "route");
      xfer(1'b0, 1'b1, a ^ 32'h4, ~seed, rv);
      xfer(1'b1, 1'b0, a, 32'h0, rv);
      chk_word(rv, seed, "core read");
      xfer(1'b0, 1'b0, a ^ 32'h4, 32'h0, rv);
      chk_word(rv, ~seed, "bus read");
    end
    rd(OFS_IRQ_STATUS, rv);
    chk_word(rv, 32'h0, "clean reads");
    $display("test routing done");
    wr(OFS_IRQ_MASK, 32'h0);
    xfer(1'b1, 1'b1, 32'h40, 32'h1234_5678, rv);
    flip = 32'h100;
    xfer(1'b1, 1'b0, 32'h40, 32'h0, rv);
    chk_word(rv, 32'h1234_5678, "corrected");
    tick(2);
    chk_bit(irq_o, 1'b0, "masked");
    wr(OFS_IRQ_MASK, 32'h3);
    tick(2);
    chk_bit(irq_o, 1'b1, "single irq");
    chk_bit(multibit_irq_o, 1'b0, "no double");
    rd(OFS_IRQ_STATUS, rv);
    chk_word(rv, 32'h1, "single status");
    tick(2);
    chk_bit(irq_o, 1'b0, "cleared");
    flip = 32'h1_0100;
    xfer(1'b0, 1'b0, 32'h40, 32'h0, rv);
    tick(2);
    chk_bit(multibit_irq_o, 1'b1, "double irq");
    chk_bit(irq_o, 1'b1, "irq on double");
    rd(OFS_IRQ_STATUS, rv);
    chk_word(rv, 32'h2, "double status");
    wr(OFS_ECC_CONTROL, 32'h0);
    flip = 32'h100;
    xfer(1'b1, 1'b0, 32'h40, 32'h0, rv);
    chk_word(rv, 32'h1234_5778, "ecc off raw");
    rd(OFS_IRQ_STATUS, rv);
    chk_word(rv, 32'h0, "ecc off quiet");
    flip = 32'h0;
    $display("test ecc done");
    wr(OFS_EXP_CONFIG_ONE, 32'h8000_0000);
    foreach (QTAB[k])
    begin
      wr(OFS_PORT_QUOTA, {24'h0, QTAB[k]});
      {maxc, maxb, run} = '0;
      log_en = 1'b1;
      fork
        repeat (20) xfer(1'b1, 1'b1, 32'h10, 32'h1, rv);
        repeat (20) xfer(1'b0, 1'b1, 32'h20, 32'h2, rv2);
      join_any
      log_en = 1'b0;
      wait fork;
      chk_bit(maxc <= q_exp(QTAB[k][3:0]) && maxc > 0, 1'b1,
              "core");
      chk_bit(maxb <= q_exp(QTAB[k][7:4]) && maxb > 0, 1'b1,
              "bus");
    end
    $display("test quota done");
    results();
  end
endmodule // testbench
